// [mrc_top.sv]
// Reset control for the common logic and all channels of the line interface.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module mrc_top
    import mrc_pkg::*;
#(
    parameter int POR_CYCLES = POR_CYC
) (
    // Clock and power-on reset.
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // Pins from outside the clock domain.
    input  wire logic                     rst_pin_n,
    input  wire logic                     ref_clk_ok,
    // Register port.
    input  wire logic [ADDR_W-1:0]        reg_addr,
    input  wire logic [DATA_W-1:0]        reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [DATA_W-1:0]        reg_rdata,
    // Common pins and resets.
    output logic                          common_rst,
    output logic                          host_data_oe,
    output logic      [GPIO_W-1:0]        gpio_oe,
    output logic                          glb_irq_mask,
    // Channel controls.
    output logic      [NUM_CH-1:0]        chan_sm_rst,
    output logic      [NUM_CH-1:0]        line_std,
    output logic      [NUM_CH-1:0]        sys_single_rail,
    output logic      [NUM_CH-1:0]        transmit_line_pair_oe,
    output logic      [NUM_CH-1:0]        receive_line_pair_oe,
    output logic      [NUM_CH*IRQ_W-1:0]  chan_irq_en
);
    mrc_state_e        state_q;
    mrc_state_e        state_d;
    logic [POR_W-1:0]  por_cnt_q;
    logic [SWC_W-1:0]  sw_cnt_q;
    logic              pin_ok;
    logic              ref_ok;
    logic              ref_ok_prev_q;
    logic              clk_ret;
    logic              glob_rst;
    logic              wr_ok;
    logic              sw_req;
    logic [DATA_W-1:0] gcf_q;
    logic [GPIO_W-1:0] gpio_dir_q;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_q;
    logic              rd_pend_q;
    logic [SLOT_W-1:0] slot;
    logic              ch_space;
    logic [DATA_W-1:0] cfg_rd  [NUM_CH];
    logic [DATA_W-1:0] mode_rd [NUM_CH];

    // The reset pin and the clock monitor level are both asynchronous.
    mrc_sync2 #(.RST_VAL(1'b1)) u_pin_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in (rst_pin_n),
        .sync_out (pin_ok)
    );

    mrc_sync2 #(.RST_VAL(1'b0)) u_ref_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in (ref_clk_ok),
        .sync_out (ref_ok)
    );

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ref_ok_prev_q <= 1'b0;
        end else begin
            ref_ok_prev_q <= ref_ok;
        end
    end

    assign clk_ret = ref_ok & ~ref_ok_prev_q;

    // One merged reset: every request lands in the state register, so the
    // whole device leaves reset on the same clock edge.
    assign glob_rst = (state_q != MRC_ST_RUN);
    assign wr_ok    = reg_wr & ~glob_rst;
    assign sw_req   = wr_ok && (reg_addr == GLB_RST_OFF);

    always_comb begin
        state_d = state_q;
        if (!pin_ok) begin
            state_d = MRC_ST_PIN;
        end else if (clk_ret) begin
            state_d = MRC_ST_POR;
        end else begin
            unique case (state_q)
                MRC_ST_POR: begin
                    if (ref_ok && por_cnt_q == POR_W'(POR_CYCLES - 1)) begin
                        state_d = MRC_ST_RUN;
                    end
                end
                MRC_ST_PIN: begin
                    state_d = MRC_ST_SW;
                end
                MRC_ST_SW: begin
                    if (sw_cnt_q == SWC_W'(SW_RST_CYC - 1)) begin
                        state_d = MRC_ST_RUN;
                    end
                end
                MRC_ST_RUN: begin
                    if (sw_req) begin
                        state_d = MRC_ST_SW;
                    end
                end
                default: begin
                    state_d = MRC_ST_POR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= MRC_ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    // Without the reference clock the power-on count never advances.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_q != MRC_ST_POR) begin
            por_cnt_q <= '0;
        end else if (ref_ok) begin
            por_cnt_q <= por_cnt_q + 1'b1;
        end
    end

    // A released pin is followed by the short software reset time so the
    // release is still taken on a clean edge.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_q != MRC_ST_SW) begin
            sw_cnt_q <= '0;
        end else begin
            sw_cnt_q <= sw_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (glob_rst) begin
            gcf_q <= GCF_RST_VAL;
        end else if (wr_ok && reg_addr == GLB_CFG_OFF) begin
            gcf_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (glob_rst) begin
            gpio_dir_q <= GPIO_RST_VAL;
        end else if (wr_ok && reg_addr == GPIO_OFF) begin
            gpio_dir_q <= reg_wdata[GPIO_W-1:0];
        end
    end

    assign slot     = reg_addr[SLOT_LSB +: SLOT_W];
    assign ch_space = (reg_addr[ADDR_W-1] == 1'b0);

    // Channel slots only decode their own index, so a channel reset
    // cannot touch global registers or a neighbouring channel.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic cfg_we;
            logic mode_we;
            assign cfg_we  = wr_ok && ch_space && reg_addr[5:0] == CH_CFG_IDX
                             && slot == SLOT_W'(gi);
            assign mode_we = wr_ok && ch_space && reg_addr[5:0] == CH_MODE_IDX
                             && slot == SLOT_W'(gi);
            mrc_chan u_chan (
                .clk_sys    (clk_sys),
                .glob_rst   (glob_rst),
                .cfg_we     (cfg_we),
                .mode_we    (mode_we),
                .wdata      (reg_wdata),
                .cfg_rdata  (cfg_rd[gi]),
                .mode_rdata (mode_rd[gi]),
                .chan_rst   (chan_sm_rst[gi]),
                .line_std   (line_std[gi]),
                .sys_fmt    (sys_single_rail[gi]),
                .tx_oe      (transmit_line_pair_oe[gi]),
                .rx_oe      (receive_line_pair_oe[gi]),
                .irq_en     (chan_irq_en[gi*IRQ_W +: IRQ_W])
            );
        end
    endgenerate

    // The global reset register holds nothing and reads as zero.
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == GLB_CFG_OFF) begin
            rd_mux = gcf_q;
        end else if (reg_addr == GPIO_OFF) begin
            rd_mux = {6'h00, gpio_dir_q};
        end else if (ch_space && reg_addr[5:0] == CH_CFG_IDX) begin
            rd_mux = cfg_rd[slot];
        end else if (ch_space && reg_addr[5:0] == CH_MODE_IDX) begin
            rd_mux = mode_rd[slot];
        end
    end

    // Read data stand for exactly the one cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (glob_rst) begin
            rdata_q   <= 8'h00;
            rd_pend_q <= 1'b0;
        end else begin
            rdata_q   <= reg_rd ? rd_mux : 8'h00;
            rd_pend_q <= reg_rd;
        end
    end

    assign reg_rdata    = rdata_q;
    assign common_rst   = glob_rst;
    assign host_data_oe = rd_pend_q & ~glob_rst;
    assign gpio_oe      = glob_rst ? '0 : gpio_dir_q;
    assign glb_irq_mask = gcf_q[GCF_GLB_IM_BIT];

    sequence sw_req_s;
        (state_q == MRC_ST_RUN) && pin_ok && !clk_ret && sw_req;
    endsequence

    sequence sw_hold_s;
        glob_rst [*8] ##[1:13] !glob_rst;
    endsequence

    sw_reset_len_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        sw_req_s |=> sw_hold_s)
        else $error("Global software reset length out of range.");

    pin_hold_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !pin_ok |=> glob_rst && state_q == MRC_ST_PIN)
        else $error("Reset pin low without reset.");

    por_done_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == MRC_ST_POR && ref_ok && pin_ok && !clk_ret
         && por_cnt_q == POR_W'(POR_CYCLES - 1)) |=> state_q == MRC_ST_RUN)
        else $error("Power-on reset did not end on time.");

    por_no_clk_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == MRC_ST_POR && !ref_ok) |=> $stable(por_cnt_q) && glob_rst)
        else $error("Power-on reset advanced without reference clock.");

    clk_return_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (pin_ok && $rose(ref_ok)) |=> state_q == MRC_ST_POR)
        else $error("Reference clock return did not reset the device.");

    pins_input_a: assert property (
        @(posedge clk_sys) glob_rst |-> (gpio_oe == '0 && !host_data_oe))
        else $error("Bus or general pins driven during reset.");

    line_hiz_a: assert property (
        @(posedge clk_sys) glob_rst |->
        (transmit_line_pair_oe == '0 && receive_line_pair_oe == '0
         && chan_sm_rst == '1))
        else $error("Line pair driven or channel running during reset.");

    irq_masked_a: assert property (
        @(posedge clk_sys) glob_rst |=> (glb_irq_mask && chan_irq_en == '0))
        else $error("Interrupts not masked after global reset.");

    gpio_read_a: assert property (
        @(posedge clk_sys) disable iff (glob_rst)
        (reg_rd && reg_addr == GPIO_OFF) |=> reg_rdata == {6'h00, $past(gpio_dir_q)})
        else $error("General pin direction read back wrong.");
endmodule // mrc_top

// [mrc_pkg.sv]
// Package of constants and types for the multichannel reset control block.
package mrc_pkg;

    // Structure.
    localparam int NUM_CH      = 16;
    localparam int ADDR_W      = 11;
    localparam int DATA_W      = 8;
    localparam int SLOT_LSB    = 6;
    localparam int SLOT_W      = 4;
    localparam int IRQ_W       = 4;
    localparam int GPIO_W      = 2;
    localparam int POR_W       = 16;
    localparam int SWC_W       = 5;

    // Global register offsets.
    localparam logic [ADDR_W-1:0] GLB_RST_OFF = 11'h040;
    localparam logic [ADDR_W-1:0] GLB_CFG_OFF = 11'h080;
    localparam logic [ADDR_W-1:0] GPIO_OFF    = 11'h100;

    // Per-channel register index within a channel slot.
    localparam logic [5:0] CH_CFG_IDX  = 6'h01;
    localparam logic [5:0] CH_MODE_IDX = 6'h02;

    // Field positions.
    localparam int CFG_LINE_STD_BIT = 0;
    localparam int CFG_SOFT_RST_BIT = 1;
    localparam int MODE_SYS_FMT_BIT = 0;
    localparam int MODE_TX_EN_BIT   = 1;
    localparam int MODE_RX_EN_BIT   = 2;
    localparam int MODE_IRQ_LSB     = 4;
    localparam int GCF_GLB_IM_BIT   = 1;

    // Reset values.
    localparam logic              LINE_STD_T1J1 = 1'b0;
    localparam logic [DATA_W-1:0] MODE_RST_VAL  = 8'h00;
    localparam logic [DATA_W-1:0] GCF_RST_VAL   = 8'h02;
    localparam logic [GPIO_W-1:0] GPIO_RST_VAL  = 2'h0;

    // Timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int POR_MAX_NS    = 1000000;
    localparam int SW_RST_MAX_NS = 1000;
    localparam int POR_CYC       = POR_MAX_NS / CLK_PERIOD_NS;
    localparam int SW_RST_CYC    = SW_RST_MAX_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        MRC_ST_POR = 4'b0001,
        MRC_ST_PIN = 4'b0010,
        MRC_ST_SW  = 4'b0100,
        MRC_ST_RUN = 4'b1000
    } mrc_state_e;

endpackage

// [mrc_sync2.sv]
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module mrc_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Level in and out.
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // mrc_sync2

// [mrc_chan.sv]
// Per-channel configuration registers and the channel software reset.
`timescale 1ns/1ps
module mrc_chan
    import mrc_pkg::*;
(
    // Clock and global-class reset.
    input  wire logic              clk_sys,
    input  wire logic              glob_rst,
    // Register writes.
    input  wire logic              cfg_we,
    input  wire logic              mode_we,
    input  wire logic [DATA_W-1:0] wdata,
    // Register read-back.
    output logic      [DATA_W-1:0] cfg_rdata,
    output logic      [DATA_W-1:0] mode_rdata,
    // Channel controls.
    output logic                   chan_rst,
    output logic                   line_std,
    output logic                   sys_fmt,
    output logic                   tx_oe,
    output logic                   rx_oe,
    output logic      [IRQ_W-1:0]  irq_en
);
    logic              ch_rst_q;
    logic [SWC_W-1:0]  cnt_q;
    logic              line_std_q;
    logic [DATA_W-1:0] mode_q;

    // The reset bit clears itself when the fixed reset time has run out.
    // A new request wins over the self-clear and restarts the reset time.
    always_ff @(posedge clk_sys) begin
        if (glob_rst) begin
            ch_rst_q <= 1'b0;
            cnt_q    <= '0;
        end else if (cfg_we && wdata[CFG_SOFT_RST_BIT]) begin
            ch_rst_q <= 1'b1;
            cnt_q    <= '0;
        end else if (ch_rst_q) begin
            if (cnt_q == SWC_W'(SW_RST_CYC - 1)) begin
                ch_rst_q <= 1'b0;
            end
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Only a global-class reset returns the line standard to T1/J1.
    always_ff @(posedge clk_sys) begin
        if (glob_rst) begin
            line_std_q <= LINE_STD_T1J1;
        end else if (cfg_we) begin
            line_std_q <= wdata[CFG_LINE_STD_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (glob_rst || ch_rst_q) begin
            mode_q <= MODE_RST_VAL;
        end else if (mode_we) begin
            mode_q <= wdata;
        end
    end

    assign chan_rst   = glob_rst | ch_rst_q;
    assign cfg_rdata  = {6'h00, ch_rst_q, line_std_q};
    assign mode_rdata = mode_q;
    assign line_std   = line_std_q;
    assign sys_fmt    = mode_q[MODE_SYS_FMT_BIT];
    assign tx_oe      = mode_q[MODE_TX_EN_BIT] & ~chan_rst;
    assign rx_oe      = mode_q[MODE_RX_EN_BIT] & ~chan_rst;
    assign irq_en     = mode_q[MODE_IRQ_LSB +: IRQ_W];

    chan_rst_end_a: assert property (
        @(posedge clk_sys) disable iff (glob_rst)
        (ch_rst_q && cnt_q == SWC_W'(SW_RST_CYC - 1)
         && !(cfg_we && wdata[CFG_SOFT_RST_BIT])) |=> !ch_rst_q && cnt_rdata_clear())
        else $error("Channel reset bit did not clear at the end of its time.");

    function automatic logic cnt_rdata_clear();
        return cfg_rdata[CFG_SOFT_RST_BIT] == 1'b0;
    endfunction

    chan_std_kept_a: assert property (
        @(posedge clk_sys) disable iff (glob_rst)
        (ch_rst_q && !cfg_we) |=> $stable(line_std_q))
        else $error("Channel reset changed the line standard.");

    chan_line_hiz_a: assert property (
        @(posedge clk_sys) ch_rst_q |-> (!tx_oe && !rx_oe))
        else $error("Line pair driven during channel reset.");

    chan_mode_clr_a: assert property (
        @(posedge clk_sys) disable iff (glob_rst)
        ch_rst_q |=> (irq_en == '0 && !sys_fmt))
        else $error("Channel reset left an interrupt source enabled.");
endmodule // mrc_chan

// [mrc_host_model.sv]
// Host microprocessor model: register port, hardware reset pin and clock presence.
`timescale 1ns/1ps
module mrc_host_model
    import mrc_pkg::*;
(
    // Clock.
    input  wire logic              clk_sys,
    // Register port.
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              host_data_oe,
    // Pins.
    output logic                   rst_pin_n,
    output logic                   ref_clk_ok
);

    logic rd_oe;

    initial begin
        reg_addr   = 11'h000;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        rst_pin_n  = 1'b1;
        ref_clk_ok = 1'b0;
        rd_oe      = 1'b0;
    end

    // One-cycle write; the data lines are scrambled afterwards so stale data never helps.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask

    // One-cycle read; the answer is taken in the single cycle where it stands.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d     = reg_rdata;
        rd_oe = host_data_oe;
    endtask

    // The caller holds the pin low for well over the minimum pulse width.
    task automatic set_pin(input logic v);
        @(posedge clk_sys);
        rst_pin_n <= v;
        #1;
    endtask

    task automatic set_ref(input logic v);
        @(posedge clk_sys);
        ref_clk_ok <= v;
        #1;
    endtask

endmodule // mrc_host_model

// [testbench.sv]
// Self-checking testbench for the multichannel reset control block.
`timescale 1ns/1ps
module testbench;
    import mrc_pkg::*;

    // A short power-on count keeps the run brief; expectations derive from it.
    localparam int POR_T = 16;

    logic                     clk_sys = 1'b0;
    logic                     sys_rst = 1'b1;
    logic [ADDR_W-1:0]        reg_addr;
    logic [DATA_W-1:0]        reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [DATA_W-1:0]        reg_rdata;
    logic                     rst_pin_n;
    logic                     ref_clk_ok;
    logic                     common_rst;
    logic                     host_data_oe;
    logic [GPIO_W-1:0]        gpio_oe;
    logic                     glb_irq_mask;
    logic [NUM_CH-1:0]        chan_sm_rst;
    logic [NUM_CH-1:0]        line_std;
    logic [NUM_CH-1:0]        sys_single_rail;
    logic [NUM_CH-1:0]        transmit_line_pair_oe;
    logic [NUM_CH-1:0]        receive_line_pair_oe;
    logic [NUM_CH*IRQ_W-1:0]  chan_irq_en;
    int                       error_cnt = 0;
    int                       checked = 0;
    logic [DATA_W-1:0]        d;
    logic                     ok;

    always #25 clk_sys = ~clk_sys;

    mrc_top #(.POR_CYCLES(POR_T)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
        .ref_clk_ok(ref_clk_ok), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .common_rst(common_rst), .host_data_oe(host_data_oe), .gpio_oe(gpio_oe),
        .glb_irq_mask(glb_irq_mask), .chan_sm_rst(chan_sm_rst), .line_std(line_std),
        .sys_single_rail(sys_single_rail), .transmit_line_pair_oe(transmit_line_pair_oe),
        .receive_line_pair_oe(receive_line_pair_oe), .chan_irq_en(chan_irq_en)
    );

    mrc_host_model host (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_data_oe(host_data_oe), .rst_pin_n(rst_pin_n), .ref_clk_ok(ref_clk_ok)
    );

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [ADDR_W-1:0] chaddr(input int ch, input logic [5:0] idx);
        chaddr = ADDR_W'((ch - 1) << SLOT_LSB) | ADDR_W'(idx);
    endfunction

    // Waits, at most max+1 cycles, for the global reset (ch < 0) or one channel to end; okay when it ended within max.
    task automatic wait_quiet(input int ch, input int max, output logic okay);
        int n;
        n = 0;
        while (((ch < 0) ? common_rst : chan_sm_rst[ch]) !== 1'b0 && n <= max) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        okay = (n <= max);
    endtask

    // Channels 3 and 5 leave their defaults, so a later reset must visibly undo it.
    task automatic program_all();
        host.wr(chaddr(3, CH_CFG_IDX), 8'h01);
        host.wr(chaddr(5, CH_CFG_IDX), 8'h01);
        host.wr(chaddr(3, CH_MODE_IDX), 8'hF7);
        host.wr(chaddr(5, CH_MODE_IDX), 8'hF7);
        host.wr(GPIO_OFF, 8'h03);
        host.wr(GLB_CFG_OFF, 8'h00);
        chk("line_std", line_std, 16'h0014);
        chk("tx_oe", transmit_line_pair_oe, 16'h0014);
        chk("irq_en", chan_irq_en, 64'h00000000000F0F00);
        chk("gpio_oe", gpio_oe, 2'h3);
        chk("glb_mask", glb_irq_mask, 1'b0);
    endtask

    task automatic check_defaults();
        chk("line_std", line_std, 16'h0000);
        chk("single_rail", sys_single_rail, 16'h0000);
        chk("tx_oe", transmit_line_pair_oe, 16'h0000);
        chk("rx_oe", receive_line_pair_oe, 16'h0000);
        chk("irq_en", chan_irq_en, 64'h0000000000000000);
        chk("glb_mask", glb_irq_mask, 1'b1);
        chk("gpio_oe", gpio_oe, 2'h0);
        chk("chan_sm_rst", chan_sm_rst, 16'h0000);
        host.rd(chaddr(5, CH_MODE_IDX), d);
        chk("ch5_mode", d, MODE_RST_VAL);
        host.rd(GLB_CFG_OFF, d);
        chk("gcf", d, GCF_RST_VAL);
        host.rd(chaddr(3, CH_CFG_IDX), d);
        chk("ch3_cfg", d, 8'h00);
    endtask

    // Watchdog well beyond the expected run of a few hundred cycles.
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (50) @(posedge clk_sys);
        #1;
        chk("por_no_ref", common_rst, 1'b1);
        host.set_ref(1'b1);
        wait_quiet(-1, POR_T + 6, ok);
        chk("por_time", ok, 1'b1);
        check_defaults();
        host.rd(11'h403, d);
        chk("unmapped", d, 8'h00);
        host.rd(GLB_RST_OFF, d);
        chk("rst_reg_read", d, 8'h00);
        // Every global-class source: register write, pin and returning reference clock.
        for (int kind = 0; kind < 3; kind++) begin
            program_all();
            host.rd(GLB_CFG_OFF, d);
            chk("read_oe", host.rd_oe, 1'b1);
            if (kind == 0) begin
                host.wr(GLB_RST_OFF, 8'hA5);
                chk("sw_start", common_rst, 1'b1);
                chk("oe_in_rst", transmit_line_pair_oe | receive_line_pair_oe, 16'h0000);
                chk("sm_in_rst", chan_sm_rst, 16'hFFFF);
                host.rd(chaddr(3, CH_CFG_IDX), d);
                chk("read_in_rst", d, 8'h00);
                chk("bus_oe_in_rst", host.rd_oe, 1'b0);
                wait_quiet(-1, SW_RST_CYC, ok);
                chk("sw_len", ok, 1'b1);
            end else if (kind == 1) begin
                host.set_pin(1'b0);
                repeat (4) @(posedge clk_sys);
                for (int i = 0; i < 30; i++) begin
                    @(posedge clk_sys);
                    #1;
                    chk("pin_hold", common_rst, 1'b1);
                    chk("pin_oe", transmit_line_pair_oe, 16'h0000);
                end
                host.set_pin(1'b1);
                wait_quiet(-1, SW_RST_CYC + 5, ok);
                chk("pin_len", ok, 1'b1);
            end else begin
                host.set_ref(1'b0);
                repeat (10) @(posedge clk_sys);
                #1;
                chk("loss_no_rst", common_rst, 1'b0);
                host.set_ref(1'b1);
                repeat (4) @(posedge clk_sys);
                #1;
                chk("ref_return", common_rst, 1'b1);
                chk("ref_sm", chan_sm_rst, 16'hFFFF);
                wait_quiet(-1, POR_T + 4, ok);
                chk("ref_len", ok, 1'b1);
            end
            check_defaults();
        end
        // Channel reset of channel 3 while channel 5 and the common logic keep running.
        program_all();
        host.wr(chaddr(3, CH_CFG_IDX), 8'h03);
        chk("ch_rst", chan_sm_rst, 16'h0004);
        chk("ch_oe", transmit_line_pair_oe | receive_line_pair_oe, 16'h0010);
        chk("ch_common", common_rst, 1'b0);
        chk("ch_gpio", gpio_oe, 2'h3);
        chk("ch_glb_mask", glb_irq_mask, 1'b0);
        wait_quiet(2, SW_RST_CYC, ok);
        chk("ch_len", ok, 1'b1);
        chk("ch_irq", chan_irq_en, 64'h00000000000F0000);
        host.rd(GPIO_OFF, d);
        chk("gpio_dir", d, 8'h03);
        host.rd(chaddr(3, CH_CFG_IDX), d);
        chk("ch_cfg", d, 8'h01);
        host.rd(chaddr(3, CH_MODE_IDX), d);
        chk("ch_mode", d, MODE_RST_VAL);
        host.rd(chaddr(5, CH_MODE_IDX), d);
        chk("other_mode", d, 8'hF7);
        chk("ch_line_std", line_std, 16'h0014);
        chk("ch_fmt", sys_single_rail, 16'h0010);
        chk("ch_after_oe", transmit_line_pair_oe, 16'h0010);
        report_and_stop();
    end

endmodule // testbench
